// ==== shared/csn_pkg.sv ====
// Constants, carriers and helpers shared by the card session negotiation block
package csn_pkg;

	localparam logic [3:0] CSN_OFS_CFG = 4'h0;
	localparam logic [3:0] CSN_OFS_STAT = 4'h4;
	localparam logic [3:0] CSN_OFS_FLAG = 4'h8;

	// Card clock cycles before a stop and after a restart
	localparam logic [10:0] CSN_STOP_WAIT_CYC = 11'h744;
	localparam logic [9:0] CSN_START_WAIT_CYC = 10'h2e8;
	// System clocks without a card clock edge that count as a stopped clock
	localparam logic [5:0] CSN_IDLE_CYC = 6'h20;

	localparam logic [7:0] CSN_TS = 8'h3b;
	localparam logic [7:0] CSN_T0_BYTE = 8'h90;
	localparam logic [3:0] CSN_TD1_MORE = 4'h8;
	localparam logic [3:0] CSN_TD_T15 = 4'hf;
	localparam logic [7:0] CSN_PPSS = 8'hff;
	localparam logic [7:0] CSN_FD_DEF = 8'h11;
	localparam logic [5:0] CSN_CLASS_A = 6'h01;
	localparam logic [1:0] CSN_CS_NONE = 2'h0;
	localparam logic [1:0] CSN_CS_ANY = 2'h3;

	localparam int CSN_FL_STOP = 0;
	localparam int CSN_FL_CMD = 1;
	localparam int CSN_FL_PPS = 2;
	localparam logic [2:0] CSN_FLAG_RST = 3'h0;

	typedef enum logic [1:0] {
		CSN_M_OFF = 2'b00,
		CSN_M_NEG = 2'b01,
		CSN_M_SPEC = 2'b10
	} csn_mode_t;

	typedef enum logic [2:0] {
		CSN_S_OFF = 3'b000,
		CSN_S_RST = 3'b001,
		CSN_S_ATR = 3'b010,
		CSN_S_WPPS = 3'b011,
		CSN_S_PRSP = 3'b100,
		CSN_S_PROTO = 3'b101,
		CSN_S_MUTE = 3'b110
	} csn_state_t;

	typedef struct packed {
		logic [7:0] ta1;
		logic [7:0] gbyte;
		logic gb_present;
		logic [1:0] clkstop;
		logic [5:0] vclass;
		logic warm_specific;
		logic t1;
	} csn_atr_t;

	typedef struct packed {
		logic lowz;
		logic usb;
		logic clf;
		logic sch;
		logic sapdu;
		logic euicc;
	} csn_feat_t;

	typedef struct packed {
		logic [7:0] fd;
		logic proto;
	} csn_sess_t;

	typedef struct packed {
		logic [7:0] fd;
		logic [7:0] pps2;
		logic proto;
	} csn_pps_t;

	typedef struct packed {
		csn_feat_t adv;
		csn_feat_t act;
		logic proto;
		logic [7:0] fd;
		logic clk_stopped;
		csn_mode_t mode;
		csn_state_t state;
	} csn_stat_t;

	localparam csn_atr_t CSN_CFG_RST = '{ta1: 8'h11, gbyte: 8'h00, gb_present: 1'b1,
		clkstop: 2'h3, vclass: 6'h07, warm_specific: 1'b0, t1: 1'b0};

	function automatic csn_feat_t csn_decode(input logic [7:0] g);
		csn_feat_t f;
		f.lowz = g[7] & g[4];
		f.usb = g[7] & g[6];
		f.clf = g[7] & g[5];
		f.sch = g[7] & g[3];
		f.sapdu = g[7] & g[3] & g[2];
		f.euicc = g[7] & g[1];
		return f;
	endfunction

endpackage

// ==== sim/csn_term.sv ====
// Terminal model: supply, reset and clock pins and the character link
`timescale 1ns/1ps
module csn_term (
	input wire logic clk,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	output logic card_clk,
	output logic card_rst_n,
	output logic card_vcc,
	output logic rx_valid,
	output logic [7:0] rx_data,
	output logic tx_ready,
	output logic tx_done
);
	logic run = 1'b0;
	logic slow = 1'b0;
	logic [7:0] got [$];
	initial begin
		card_clk = 1'b0;
		card_rst_n = 1'b0;
		card_vcc = 1'b0;
		rx_valid = 1'b0;
		rx_data = 8'h00;
		tx_ready = 1'b0;
		tx_done = 1'b0;
	end
	// Clock stands low while stopped; phase unrelated to the system clock
	initial begin
		#13;
		forever begin
			#80;
			card_clk = run ? ~card_clk : 1'b0;
		end
	end
	always @(posedge clk) begin
		tx_ready <= slow ? 1'($urandom_range(1)) : 1'b1;
		tx_done <= tx_valid && tx_ready;
		if (tx_valid && tx_ready)
			got.push_back(tx_data);
	end
	task automatic pins(input logic v, input logic r);
		@(posedge clk);
		card_vcc <= v;
		card_rst_n <= r;
	endtask
	// Released data shows the inverse so a stale byte never passes
	task automatic send(input logic [7:0] b);
		@(posedge clk);
		rx_valid <= 1'b1;
		rx_data <= b;
		@(posedge clk);
		rx_valid <= 1'b0;
		rx_data <= ~b;
		repeat (2) @(posedge clk);
	endtask
endmodule

// ==== sim/csn_top_chk.sv ====
// Port-level assertions for the card session block
`timescale 1ns/1ps
module csn_top_chk #(
	parameter logic [5:0] IDLE_CYC = csn_pkg::CSN_IDLE_CYC
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic card_clk,
	input wire logic card_rst_n,
	input wire logic card_vcc,
	input wire logic tx_ready,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	input wire csn_pkg::csn_sess_t sess,
	input wire csn_pkg::csn_feat_t feat_adv,
	input wire csn_pkg::csn_mode_t mode,
	input wire logic err_rep_en,
	input wire logic sec_clr,
	input wire logic clk_stopped
);
	logic cold_r, cold_nxt, ck_r;
	logic [7:0] idle_r, idle_nxt;
	// Idle count runs on the raw pin, so it leads the block's synchronised view
	always_comb begin
		cold_nxt = cold_r;
		if (!card_vcc)
			cold_nxt = 1'b1;
		else if (sec_clr)
			cold_nxt = 1'b0;
		idle_nxt = (idle_r == 8'hff) ? idle_r : idle_r + 8'h01;
		if (card_clk && !ck_r)
			idle_nxt = 8'h00;
	end
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cold_r <= 1'b1;
			ck_r <= 1'b0;
			idle_r <= 8'h00;
		end else begin
			cold_r <= cold_nxt;
			ck_r <= card_clk;
			idle_r <= idle_nxt;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	a_sec_pulse: assert property ($rose(card_rst_n) && card_vcc |-> ##[2:5] sec_clr ##1 !sec_clr)
		else $error("security clear pulse missing after reset release");
	a_cold_neg: assert property (sec_clr && cold_r |-> mode == csn_pkg::CSN_M_NEG)
		else $error("cold reset did not enter negotiable mode");
	a_atr_first: assert property (sec_clr |-> ##[0:1] (tx_valid && tx_data == csn_pkg::CSN_TS))
		else $error("answer does not open with the initial character");
	a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
		else $error("offered byte changed before it was taken");
	a_spec_hold: assert property (mode == csn_pkg::CSN_M_SPEC && $past(mode) == mode |-> $stable(sess))
		else $error("session parameters moved in specific mode");
	a_rep_on: assert property ($past(card_vcc, 3) && !sess.proto |-> err_rep_en)
		else $error("error repetition off under T=0");
	a_rep_off: assert property (sess.proto |-> !err_rep_en)
		else $error("error repetition on under T=1");
	a_sapdu_sch: assert property (feat_adv.sapdu |-> feat_adv.sch)
		else $error("platform exchange flagged without secure channel");
	a_stop_idle: assert property ($rose(clk_stopped) |-> idle_r >= IDLE_CYC && idle_r <= IDLE_CYC + 6)
		else $error("clock stop seen after wrong idle time");
	a_stop_wake: assert property (clk_stopped && card_clk && !ck_r |-> ##[1:6] !clk_stopped)
		else $error("clock restart not seen");
endmodule
bind csn_top csn_top_chk #(.IDLE_CYC(IDLE_CYC)) u_chk (.clk(clk), .resetn(resetn),
	.card_clk(card_clk), .card_rst_n(card_rst_n), .card_vcc(card_vcc), .tx_ready(tx_ready),
	.tx_valid(tx_valid), .tx_data(tx_data), .sess(sess), .feat_adv(feat_adv), .mode(mode),
	.err_rep_en(err_rep_en), .sec_clr(sec_clr), .clk_stopped(clk_stopped));

// ==== sim/test_csn_top.sv ====
// Self-checking bench for the card session block
`timescale 1ns/1ps
module test_csn_top;
	logic clk, resetn, card_clk, card_rst_n, card_vcc, rx_valid, tx_ready, tx_done, tx_valid;
	logic reg_wr, reg_rd, proto_run, err_rep_en, sec_clr, clk_stopped, gbp, t1;
	logic [7:0] rx_data, tx_data, g, ta1, x;
	logic [3:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, v;
	logic [26:0] cfg;
	logic [7:0] atr [0:9];
	logic [7:0] pps [0:9];
	csn_pkg::csn_sess_t sess;
	csn_pkg::csn_feat_t feat_act, feat_adv;
	csn_pkg::csn_mode_t mode;
	int n_mismatch = 0;
	int checks = 0;
	int na, np;
	csn_top #(.IDLE_CYC(6'h10)) dut (.clk(clk), .resetn(resetn), .card_clk(card_clk),
		.card_rst_n(card_rst_n), .card_vcc(card_vcc), .rx_valid(rx_valid), .rx_data(rx_data),
		.tx_ready(tx_ready), .tx_done(tx_done), .tx_valid(tx_valid), .tx_data(tx_data),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .sess(sess), .feat_act(feat_act), .feat_adv(feat_adv),
		.mode(mode), .proto_run(proto_run), .err_rep_en(err_rep_en), .sec_clr(sec_clr),
		.clk_stopped(clk_stopped));
	csn_term u_term (.clk(clk), .tx_valid(tx_valid), .tx_data(tx_data), .card_clk(card_clk),
		.card_rst_n(card_rst_n), .card_vcc(card_vcc), .rx_valid(rx_valid), .rx_data(rx_data),
		.tx_ready(tx_ready), .tx_done(tx_done));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task automatic summarize();
		$display("checks=%0d mismatches=%0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic cmpv(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	// Bounded waits: a hang ends the run with a mismatch
	task automatic wait_tx(input int n);
		int i;
		for (i = 0; i < 3000 && u_term.got.size() < n; i++)
			@(posedge clk);
		if (i == 3000) begin
			n_mismatch++;
			summarize();
		end
		repeat (5) @(posedge clk);
		#1;
	endtask
	task automatic wait_stop(input logic s);
		int i;
		for (i = 0; i < 300 && clk_stopped !== s; i++)
			@(posedge clk);
		if (i == 300) begin
			n_mismatch++;
			summarize();
		end
	endtask
	task automatic card_rst(input logic cold);
		if (cold) begin
			u_term.pins(1'b0, 1'b0);
			repeat (10) @(posedge clk);
		end
		u_term.pins(1'b1, 1'b0);
		repeat (10) @(posedge clk);
		u_term.got.delete();
		u_term.run <= 1'b1;
		u_term.pins(1'b1, 1'b1);
	endtask
	task automatic chk_tx(input logic [7:0] e [0:9], input int n);
		cmpv(32'(u_term.got.size()), 32'(n));
		for (int i = 0; i < n; i++)
			cmpv(32'(u_term.got[i]), 32'(e[i]));
	endtask
	function automatic logic [5:0] feat(input logic [7:0] b);
		return {b[7] & b[4], b[7] & b[6], b[7] & b[5], b[7] & b[3], b[7] & b[3] & b[2], b[7] & b[1]};
	endfunction
	function automatic int build(input logic [26:0] c);
		int n;
		logic [7:0] s;
		atr[0] = 8'h3b;
		atr[1] = 8'h90;
		atr[2] = c[26:19];
		atr[3] = {4'h8, 3'h0, c[0]};
		atr[4] = {2'h0, c[10], 1'b1, 4'hf};
		atr[5] = {(c[7:2] != 6'h01 && c[9:8] == 2'h0) ? 2'h3 : c[9:8], c[7:2]};
		n = 6;
		if (c[10]) begin
			atr[n] = c[18:11];
			n++;
		end
		s = 8'h00;
		for (int i = 1; i < n; i++)
			s ^= atr[i];
		if (c[0]) begin
			atr[n] = s;
			n++;
		end
		return n;
	endfunction
	initial begin
		resetn = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		void'($urandom(32'h6d74));
		repeat (20) @(posedge clk);
		resetn <= 1'b1;
		rd(4'h0, v);
		cmpv(v, 32'h088071c);
		rd(4'($urandom_range(15, 9)), v);
		cmpv(v, 32'h0);
		for (int k = 0; k < 6; k++) begin
			g = (k == 0) ? 8'h00 : (k == 1) ? 8'h90 : (k == 2) ? 8'h8c : (k == 3) ? 8'h7f :
				(k == 4) ? 8'hff : 8'($urandom);
			gbp = (k != 3);
			ta1 = 8'($urandom);
			t1 = 1'($urandom);
			cfg = {ta1, g, gbp, 2'($urandom), 6'($urandom_range(63, 1)), k[0], t1};
			wr(4'h0, {5'h0, cfg});
			u_term.slow <= k[0];
			card_rst(1'b1);
			na = build(cfg);
			wait_tx(na);
			chk_tx(atr, na);
			cmpv(32'(feat_adv), 32'(gbp ? feat(g) : 6'h0));
			cmpv(32'(mode), 32'(csn_pkg::CSN_M_NEG));
			pps[0] = 8'hff;
			pps[1] = {2'h0, gbp, 1'b1, 3'h0, t1};
			pps[2] = ta1;
			pps[3] = 8'($urandom);
			np = gbp ? 4 : 3;
			x = 8'h00;
			for (int i = 0; i < np; i++)
				x ^= pps[i];
			pps[np] = x;
			np++;
			u_term.got.delete();
			for (int i = 0; i < np; i++)
				u_term.send(pps[i]);
			wait_tx(np);
			chk_tx(pps, np);
			cmpv(32'(sess), 32'({ta1, t1}));
			cmpv(32'(feat_act), 32'(gbp ? feat(g) & feat(pps[3]) : 6'h0));
			cmpv(32'({proto_run, err_rep_en}), 32'({1'b1, ~t1}));
			if (k == 0) begin
				rd(4'h8, v);
				cmpv(v, 32'h2);
				wr(4'h8, 32'h7);
				u_term.run <= 1'b0;
				wait_stop(1'b1);
				u_term.run <= 1'b1;
				wait_stop(1'b0);
				u_term.send(8'h00);
				rd(4'h8, v);
				cmpv(v, 32'h3);
				wr(4'h8, 32'h3);
				rd(4'h8, v);
				cmpv(v, 32'h0);
				repeat (1870 * 8) @(posedge clk);
				u_term.run <= 1'b0;
				wait_stop(1'b1);
				u_term.run <= 1'b1;
				repeat (760 * 8) @(posedge clk);
				u_term.send(8'h00);
				rd(4'h8, v);
				cmpv(v, 32'h0);
			end
			wr(4'h0, {5'h0, ~cfg});
			card_rst(1'b0);
			wait_tx(na);
			chk_tx(atr, na);
			cmpv(32'(mode), 32'(k[0] ? csn_pkg::CSN_M_SPEC : csn_pkg::CSN_M_NEG));
			cmpv(32'(sess), 32'(k[0] ? {ta1, t1} : {8'h11, t1}));
			$display("test %0d done", k);
		end
		wr(4'h0, 32'h088071c);
		card_rst(1'b1);
		na = build(27'h088071c);
		for (int r = 0; r < 3; r++) begin
			wait_tx(na);
			chk_tx(atr, na);
			if (r < 2)
				card_rst(1'b0);
		end
		u_term.got.delete();
		u_term.send(8'hff);
		u_term.send(8'h10);
		u_term.send(8'h12);
		u_term.send(8'hff ^ 8'h10 ^ 8'h12);
		repeat (20) @(posedge clk);
		cmpv(32'(u_term.got.size()), 32'h0);
		rd(4'h4, v);
		cmpv(32'(v[2:0]), 32'h6);
		rd(4'h8, v);
		cmpv(v, 32'h4);
		card_rst(1'b0);
		wait_tx(7);
		u_term.got.delete();
		pps[0] = 8'hff;
		pps[1] = 8'h00;
		pps[2] = 8'hff;
		for (int i = 0; i < 3; i++)
			u_term.send(pps[i]);
		wait_tx(3);
		chk_tx(pps, 3);
		cmpv(32'(sess), 32'({8'h11, 1'b0}));
		card_rst(1'b0);
		wait_tx(7);
		u_term.send(8'h00);
		rd(4'h4, v);
		cmpv(32'(v[14:0]), 32'({1'b0, 8'h11, 1'b0, 2'h1, 3'h5}));
		$display("test reject done");
		summarize();
	end
endmodule

// ==== verilog/csn_pps.sv ====
// Receiver and checker for the parameter selection request
`timescale 1ns/1ps
module csn_pps (
	input wire logic clk,
	input wire logic resetn,
	input wire logic en,
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	input wire logic [7:0] adv_fd,
	input wire logic gb_present,
	input wire logic offer_t1,
	output logic busy,
	output logic done,
	output logic ok,
	output csn_pkg::csn_pps_t req,
	output logic [2:0] len,
	output logic [47:0] bytes
);
	logic [2:0] cnt_r, cnt_nxt;
	logic [47:0] buf_r, buf_nxt;
	logic [7:0] x_r, x_nxt;
	logic done_r, done_nxt;
	logic ok_r, ok_nxt;
	csn_pkg::csn_pps_t req_r, req_nxt;
	logic [2:0] len_r, len_nxt;

	always_comb begin
		logic [7:0] p0;
		logic [7:0] f1;
		logic [7:0] f2;
		logic [2:0] i2;
		logic [2:0] need;
		p0 = (cnt_r == 3'h1) ? rx_data : buf_r[15:8];
		need = 3'h3 + {2'h0, p0[4]} + {2'h0, p0[5]} + {2'h0, p0[6]};
		i2 = p0[4] ? 3'h3 : 3'h2;
		f1 = csn_pkg::CSN_FD_DEF;
		f2 = 8'h00;
		cnt_nxt = cnt_r;
		buf_nxt = buf_r;
		x_nxt = x_r;
		done_nxt = 1'b0;
		ok_nxt = ok_r;
		req_nxt = req_r;
		len_nxt = len_r;
		if (!en) begin
			cnt_nxt = 3'h0;
			x_nxt = 8'h00;
		end else if (rx_valid && !(cnt_r == 3'h0 && rx_data != csn_pkg::CSN_PPSS)) begin
			buf_nxt[{cnt_r, 3'h0} +: 8] = rx_data;
			x_nxt = x_r ^ rx_data;
			cnt_nxt = cnt_r + 3'h1;
			if (cnt_nxt == need) begin
				if (p0[4]) f1 = buf_nxt[23:16];
				if (p0[5]) f2 = buf_nxt[{i2, 3'h0} +: 8];
				done_nxt = 1'b1;
				cnt_nxt = 3'h0;
				x_nxt = 8'h00;
				len_nxt = need;
				req_nxt = '{fd: f1, pps2: f2, proto: p0[0]};
				// Speed within advertised range, PPS2 only with a global byte
				ok_nxt = (x_r == rx_data) && p0[7] == 1'b0
					&& f1[7:4] <= adv_fd[7:4] && f1[3:0] <= adv_fd[3:0]
					&& (!p0[5] || gb_present)
					&& p0[3:0] == {3'h0, offer_t1};
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt_r <= 3'h0;
			buf_r <= 48'h0;
			x_r <= 8'h00;
			done_r <= 1'b0;
			ok_r <= 1'b0;
			req_r <= '{fd: csn_pkg::CSN_FD_DEF, pps2: 8'h00, proto: 1'b0};
			len_r <= 3'h0;
		end else begin
			cnt_r <= cnt_nxt;
			buf_r <= buf_nxt;
			x_r <= x_nxt;
			done_r <= done_nxt;
			ok_r <= ok_nxt;
			req_r <= req_nxt;
			len_r <= len_nxt;
		end
	end

	assign busy = (cnt_r != 3'h0);
	assign done = done_r;
	assign ok = ok_r;
	assign req = req_r;
	assign len = len_r;
	assign bytes = buf_r;
endmodule

// ==== verilog/csn_sync.sv ====
// Two-stage synchroniser for pins entering the system clock domain
`timescale 1ns/1ps
module csn_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s1_r <= '0;
			s2_r <= '0;
		end else begin
			s1_r <= d;
			s2_r <= s1_r;
		end
	end

	assign q = s2_r;
endmodule

// ==== verilog/csn_top.sv ====
// Card-side session control: resets, answer to reset, PPS and clock stop watch
//
// Implementation choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
module csn_top #(
	parameter logic [5:0] IDLE_CYC = csn_pkg::CSN_IDLE_CYC
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic card_clk,
	input wire logic card_rst_n,
	input wire logic card_vcc,
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	input wire logic tx_ready,
	input wire logic tx_done,
	output logic tx_valid,
	output logic [7:0] tx_data,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output csn_pkg::csn_sess_t sess,
	output csn_pkg::csn_feat_t feat_act,
	output csn_pkg::csn_feat_t feat_adv,
	output csn_pkg::csn_mode_t mode,
	output logic proto_run,
	output logic err_rep_en,
	output logic sec_clr,
	output logic clk_stopped
);
	logic [2:0] pin_s;
	logic ck_s, rst_s, vcc_s;
	logic pps_busy, pps_done, pps_ok;
	csn_pkg::csn_pps_t pps_req;
	logic [2:0] pps_len;
	logic [47:0] pps_bytes;

	csn_pkg::csn_state_t st_r, st_nxt;
	csn_pkg::csn_mode_t mode_r, mode_nxt;
	csn_pkg::csn_sess_t sess_r, sess_nxt;
	csn_pkg::csn_feat_t feat_r, feat_nxt;
	csn_pkg::csn_atr_t atr_r, atr_nxt;
	logic cold_r, cold_nxt;
	logic [2:0] idx_r, idx_nxt;
	logic [7:0] txd_r, txd_nxt;
	logic sec_r, sec_nxt;
	logic erp_r, erp_nxt;
	logic pps_rej;

	logic ckd_r;
	logic [5:0] idle_r, idle_nxt;
	logic stp_r, stp_nxt;
	logic [10:0] stx_r, stx_nxt;
	logic [9:0] sgo_r, sgo_nxt;
	logic wcmd_r, wcmd_nxt;
	logic set_stop, set_cmd;

	csn_pkg::csn_atr_t cfg_r, cfg_nxt;
	logic [2:0] flg_r, flg_nxt;
	logic [31:0] rd_r, rd_nxt;
	csn_pkg::csn_stat_t stat;

	csn_sync #(.W(3)) u_sync (
		.clk(clk),
		.resetn(resetn),
		.d({card_clk, card_rst_n, card_vcc}),
		.q(pin_s)
	);
	assign ck_s = pin_s[2];
	assign rst_s = pin_s[1];
	assign vcc_s = pin_s[0];

	csn_pps u_pps (
		.clk(clk),
		.resetn(resetn),
		.en(st_r == csn_pkg::CSN_S_WPPS),
		.rx_valid(rx_valid),
		.rx_data(rx_data),
		.adv_fd(atr_r.ta1),
		.gb_present(atr_r.gb_present),
		.offer_t1(atr_r.t1),
		.busy(pps_busy),
		.done(pps_done),
		.ok(pps_ok),
		.req(pps_req),
		.len(pps_len),
		.bytes(pps_bytes)
	);

	// Byte i of the answer to reset; depends only on the latched settings
	function automatic logic [7:0] atr_byte(input csn_pkg::csn_atr_t a, input logic [2:0] i);
		logic [1:0] cs;
		logic [7:0] td1;
		logic [7:0] td2;
		logic [7:0] ta3;
		logic [7:0] tck;
		cs = a.clkstop;
		if (a.vclass != csn_pkg::CSN_CLASS_A && a.clkstop == csn_pkg::CSN_CS_NONE)
			cs = csn_pkg::CSN_CS_ANY;
		td1 = {csn_pkg::CSN_TD1_MORE, 3'h0, a.t1};
		td2 = {2'h0, a.gb_present, 1'b1, csn_pkg::CSN_TD_T15};
		ta3 = {cs, a.vclass};
		tck = csn_pkg::CSN_T0_BYTE ^ a.ta1 ^ td1 ^ td2 ^ ta3 ^ (a.gb_present ? a.gbyte : 8'h00);
		case (i)
			3'h0: atr_byte = csn_pkg::CSN_TS;
			3'h1: atr_byte = csn_pkg::CSN_T0_BYTE;
			3'h2: atr_byte = a.ta1;
			3'h3: atr_byte = td1;
			3'h4: atr_byte = td2;
			3'h5: atr_byte = ta3;
			3'h6: atr_byte = a.gb_present ? a.gbyte : tck;
			default: atr_byte = tck;
		endcase
	endfunction

	// Session state machine
	always_comb begin
		logic [2:0] atr_last;
		atr_last = 3'h5 + {2'h0, atr_r.gb_present} + {2'h0, atr_r.t1};
		st_nxt = st_r;
		mode_nxt = mode_r;
		sess_nxt = sess_r;
		feat_nxt = feat_r;
		atr_nxt = atr_r;
		cold_nxt = cold_r;
		idx_nxt = idx_r;
		sec_nxt = 1'b0;
		pps_rej = 1'b0;
		if (!vcc_s) begin
			// Contacts off: the next reset is a cold one
			st_nxt = csn_pkg::CSN_S_OFF;
			mode_nxt = csn_pkg::CSN_M_OFF;
			cold_nxt = 1'b1;
			feat_nxt = '0;
		end else if (!rst_s) begin
			st_nxt = csn_pkg::CSN_S_RST;
			idx_nxt = 3'h0;
		end else begin
			case (st_r)
				csn_pkg::CSN_S_RST: begin
					sec_nxt = 1'b1;
					st_nxt = csn_pkg::CSN_S_ATR;
					idx_nxt = 3'h0;
					if (cold_r) begin
						cold_nxt = 1'b0;
						atr_nxt = cfg_r;
						mode_nxt = csn_pkg::CSN_M_NEG;
						sess_nxt = '{fd: csn_pkg::CSN_FD_DEF, proto: cfg_r.t1};
						feat_nxt = '0;
					end else if (atr_r.warm_specific) begin
						mode_nxt = csn_pkg::CSN_M_SPEC;
					end else begin
						mode_nxt = csn_pkg::CSN_M_NEG;
						sess_nxt = '{fd: csn_pkg::CSN_FD_DEF, proto: atr_r.t1};
						feat_nxt = '0;
					end
				end
				csn_pkg::CSN_S_ATR: begin
					if (tx_ready) begin
						// Every announced character goes out, none dropped
						if (idx_r == atr_last) begin
							idx_nxt = 3'h0;
							st_nxt = (mode_r == csn_pkg::CSN_M_SPEC) ?
								csn_pkg::CSN_S_PROTO : csn_pkg::CSN_S_WPPS;
						end else begin
							idx_nxt = idx_r + 3'h1;
						end
					end
				end
				csn_pkg::CSN_S_WPPS: begin
					if (pps_done) begin
						if (pps_ok) begin
							st_nxt = csn_pkg::CSN_S_PRSP;
							idx_nxt = 3'h0;
							sess_nxt = '{fd: pps_req.fd, proto: pps_req.proto};
							// Only features both offered and requested become active
							feat_nxt = csn_pkg::csn_feat_t'(csn_pkg::csn_decode(pps_req.pps2)
								& feat_adv);
						end else begin
							// A bad request leaves the card silent until reset
							st_nxt = csn_pkg::CSN_S_MUTE;
							pps_rej = 1'b1;
						end
					end else if (rx_valid && !pps_busy && rx_data != csn_pkg::CSN_PPSS) begin
						st_nxt = csn_pkg::CSN_S_PROTO;
					end
				end
				csn_pkg::CSN_S_PRSP: begin
					if (tx_ready) begin
						if (idx_r == pps_len - 3'h1) begin
							st_nxt = csn_pkg::CSN_S_PROTO;
							idx_nxt = 3'h0;
						end else begin
							idx_nxt = idx_r + 3'h1;
						end
					end
				end
				csn_pkg::CSN_S_OFF, csn_pkg::CSN_S_PROTO, csn_pkg::CSN_S_MUTE: begin
					st_nxt = st_r;
				end
				default: begin
					st_nxt = csn_pkg::CSN_S_OFF;
				end
			endcase
		end
		if (st_nxt == csn_pkg::CSN_S_PRSP)
			txd_nxt = pps_bytes[{idx_nxt, 3'h0} +: 8];
		else
			txd_nxt = atr_byte(atr_nxt, idx_nxt);
		erp_nxt = vcc_s && !sess_nxt.proto;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st_r <= csn_pkg::CSN_S_OFF;
			mode_r <= csn_pkg::CSN_M_OFF;
			sess_r <= '{fd: csn_pkg::CSN_FD_DEF, proto: 1'b0};
			feat_r <= '0;
			atr_r <= csn_pkg::CSN_CFG_RST;
			cold_r <= 1'b1;
			idx_r <= 3'h0;
			txd_r <= 8'h00;
			sec_r <= 1'b0;
			erp_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			mode_r <= mode_nxt;
			sess_r <= sess_nxt;
			feat_r <= feat_nxt;
			atr_r <= atr_nxt;
			cold_r <= cold_nxt;
			idx_r <= idx_nxt;
			txd_r <= txd_nxt;
			sec_r <= sec_nxt;
			erp_r <= erp_nxt;
		end
	end

	// Card clock watch; the pin is sampled, so a stop is only seen after IDLE_CYC
	always_comb begin
		logic edge_s;
		edge_s = ck_s & ~ckd_r;
		idle_nxt = edge_s ? 6'h00 : ((idle_r == IDLE_CYC) ? idle_r : idle_r + 6'h01);
		stp_nxt = (idle_nxt == IDLE_CYC);
		stx_nxt = stx_r;
		if (tx_done)
			stx_nxt = 11'h000;
		else if (edge_s && stx_r < csn_pkg::CSN_STOP_WAIT_CYC)
			stx_nxt = stx_r + 11'h001;
		sgo_nxt = sgo_r;
		wcmd_nxt = wcmd_r;
		set_cmd = 1'b0;
		if (stp_r && edge_s) begin
			sgo_nxt = 10'h000;
			wcmd_nxt = 1'b1;
		end else if (edge_s && sgo_r < csn_pkg::CSN_START_WAIT_CYC) begin
			sgo_nxt = sgo_r + 10'h001;
		end
		if (rx_valid) begin
			wcmd_nxt = 1'b0;
			set_cmd = wcmd_r && sgo_r < csn_pkg::CSN_START_WAIT_CYC;
		end
		set_stop = !stp_r && stp_nxt && st_r == csn_pkg::CSN_S_PROTO
			&& stx_r < csn_pkg::CSN_STOP_WAIT_CYC;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ckd_r <= 1'b0;
			idle_r <= 6'h00;
			stp_r <= 1'b0;
			stx_r <= csn_pkg::CSN_STOP_WAIT_CYC;
			sgo_r <= csn_pkg::CSN_START_WAIT_CYC;
			wcmd_r <= 1'b0;
		end else begin
			ckd_r <= ck_s;
			idle_r <= idle_nxt;
			stp_r <= stp_nxt;
			stx_r <= stx_nxt;
			sgo_r <= sgo_nxt;
			wcmd_r <= wcmd_nxt;
		end
	end

	// Register port; flag events win over a same-cycle clear
	always_comb begin
		logic [2:0] clr;
		logic [2:0] set;
		cfg_nxt = cfg_r;
		clr = 3'h0;
		set = 3'h0;
		set[csn_pkg::CSN_FL_STOP] = set_stop;
		set[csn_pkg::CSN_FL_CMD] = set_cmd;
		set[csn_pkg::CSN_FL_PPS] = pps_rej;
		if (reg_wr && reg_addr == csn_pkg::CSN_OFS_CFG)
			cfg_nxt = csn_pkg::csn_atr_t'(reg_wdata[26:0]);
		if (reg_wr && reg_addr == csn_pkg::CSN_OFS_FLAG)
			clr = reg_wdata[2:0];
		flg_nxt = (flg_r & ~clr) | set;
		rd_nxt = 32'h0;
		if (reg_rd) begin
			case (reg_addr)
				csn_pkg::CSN_OFS_CFG: rd_nxt = {5'h0, cfg_r};
				csn_pkg::CSN_OFS_STAT: rd_nxt = {5'h0, stat};
				csn_pkg::CSN_OFS_FLAG: rd_nxt = {29'h0, flg_r};
				default: rd_nxt = 32'h0;
			endcase
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cfg_r <= csn_pkg::CSN_CFG_RST;
			flg_r <= csn_pkg::CSN_FLAG_RST;
			rd_r <= 32'h0;
		end else begin
			cfg_r <= cfg_nxt;
			flg_r <= flg_nxt;
			rd_r <= rd_nxt;
		end
	end

	// Zero byte or b8 clear decodes to no features; absent byte offers nothing
	assign feat_adv = atr_r.gb_present ? csn_pkg::csn_decode(atr_r.gbyte) : '0;
	assign stat = '{adv: feat_adv, act: feat_r, proto: sess_r.proto, fd: sess_r.fd,
		clk_stopped: stp_r, mode: mode_r, state: st_r};

	assign tx_valid = (st_r == csn_pkg::CSN_S_ATR) || (st_r == csn_pkg::CSN_S_PRSP);
	assign tx_data = txd_r;
	assign reg_rdata = rd_r;
	assign sess = sess_r;
	assign feat_act = feat_r;
	assign mode = mode_r;
	assign proto_run = (st_r == csn_pkg::CSN_S_PROTO);
	assign err_rep_en = erp_r;
	assign sec_clr = sec_r;
	assign clk_stopped = stp_r;
endmodule
